// ---- rirq_consts.vh ----
// Constants for the radio interrupt source select block.
// Assumes inclusion by every design file that needs the map; definitions only.
`ifndef RIRQ_CONSTS_VH
`define RIRQ_CONSTS_VH

// Register indices; byte address is four times the index
`define RIRQ_IDX_CFG        6'h0D
`define RIRQ_IDX_MODE       6'h10
`define RIRQ_IDX_THRESH     6'h11
`define RIRQ_IDX_ISTAT      6'h12
`define RIRQ_IDX_IMASK      6'h13
`define RIRQ_IDX_QLEVEL     6'h14

// Routing and status register field positions
`define RIRQ_CFG_L0_HI      7
`define RIRQ_CFG_L0_LO      6
`define RIRQ_CFG_L1_HI      5
`define RIRQ_CFG_L1_LO      4
`define RIRQ_CFG_TXSEL      3
`define RIRQ_CFG_FULL       2
`define RIRQ_CFG_HASDATA    1
`define RIRQ_CFG_OVR        0

// Mode register field positions
`define RIRQ_MODE_DM_HI     1
`define RIRQ_MODE_DM_LO     0
`define RIRQ_MODE_ST_HI     3
`define RIRQ_MODE_ST_LO     2
`define RIRQ_MODE_AFILT     4

// Interrupt status bit positions
`define RIRQ_IS_LINE0       0
`define RIRQ_IS_LINE1       1
`define RIRQ_IS_OVR         2
`define RIRQ_IS_TX_COMPLETE_EVENT      3

// Reset values
`define RIRQ_RST_CFG        5'h0_0
`define RIRQ_RST_MODE       5'h0_0
`define RIRQ_RST_THRESH     6'h0_F
`define RIRQ_RST_IMASK      4'h0

// Data modes and operating states
`define RIRQ_DM_CONT        2'h0
`define RIRQ_DM_BUF         2'h1
`define RIRQ_ST_STBY        2'h0
`define RIRQ_ST_RX          2'h1
`define RIRQ_ST_TX          2'h2
`define RIRQ_ST_SLEEP       2'h3

// Queue depth in bytes
`define RIRQ_QDEPTH         7'h40

`endif

// ---- rirq_route.v ----
// Source selection for the two interrupt lines.
// Pure combinational; the caller registers the results.
`timescale 1ns/1ps
`include "rirq_consts.vh"

module rirq_route (
   // Configuration
   input  wire [1:0] i_data_mode_sel,
   input  wire [1:0] i_op_state,
   input  wire [1:0] i_line0_rx_source_sel,
   input  wire [1:0] i_line1_rx_source_sel,
   input  wire       i_line1_tx_source_sel,
   input  wire       i_addr_filter_en,
   // Sources
   input  wire       i_sync_event,
   input  wire       i_address_match_event,
   input  wire       i_signal_strength_event,
   input  wire       i_recovered_bit_clock,
   input  wire       i_byte_written_event,
   input  wire       i_payload_ready_event,
   input  wire       i_crc_pass_event,
   input  wire       i_tx_complete_event,
   input  wire       i_queue_empty,
   input  wire       i_queue_full,
   input  wire       i_queue_thresh,
   // Selected lines
   output reg        o_line0,
   output reg        o_line1
);

   reg pkt;
   reg cont;

   // Mode decode, then per-mode selection tables
   always @* begin
      cont = (i_data_mode_sel == `RIRQ_DM_CONT);
      pkt  = i_data_mode_sel[1];
      o_line0 = 1'b0;
      o_line1 = 1'b0;
      if (i_op_state == `RIRQ_ST_TX) begin
         if (cont)
            o_line1 = i_recovered_bit_clock;
         else
            o_line1 = i_line1_tx_source_sel ? i_tx_complete_event : i_queue_full;
      end else if (i_op_state != `RIRQ_ST_SLEEP) begin
         // Queue sources run in standby as well as receive
         if (cont) begin
            o_line0 = (i_line0_rx_source_sel == 2'h1) ? i_signal_strength_event : i_sync_event;
            o_line1 = i_recovered_bit_clock;
         end else begin
            case (i_line0_rx_source_sel)
               2'h3:    o_line0 = (pkt && i_addr_filter_en) ? i_address_match_event
                                                            : i_sync_event;
               2'h2:    o_line0 = i_queue_empty;
               2'h1:    o_line0 = i_byte_written_event;
               default: o_line0 = pkt & i_payload_ready_event;
            endcase
            case (i_line1_rx_source_sel)
               2'h3:    o_line1 = i_queue_thresh;
               2'h2:    o_line1 = i_signal_strength_event;
               2'h1:    o_line1 = i_queue_full;
               default: o_line1 = pkt & i_crc_pass_event;
            endcase
         end
      end
   end

endmodule // rirq_route

// ---- rirq_top.v ----
// Interrupt routing, queue status and register file of the radio block.
// Assumes an APB master on i_clk and radio core event levels on the same clock,
// except the recovered bit clock and signal strength, which arrive from outside.
// Push, pop and transmit strobes are one-clock pulses from the core;
// the core empties its byte storage on the flush pulse.
// Overview of operation
// - In continuous mode during receive or standby, line 0 shows sync for codes 11, 10, 00 and signal strength for 01.
// - In buffer mode during receive or standby, line 0 shows sync, queue empty, byte written or nothing for 11, 10, 01, 00.
// - In packet mode during receive or standby, line 0 shows sync or address match, queue empty, byte written, payload ready.
// - Line 1 in receive or standby is the bit clock in continuous mode, else threshold, strength, full, then none or CRC pass.
// - In transmit, line 1 is the bit clock in continuous mode, else transmit complete when bit 3 is 1 and queue full when 0.
// - Data mode 00 is continuous, 01 buffer and either 1x code packet.
// - Queue empty, threshold and full sources also work in standby.
// - Status bit 2 reads 1 while the queue is full and mirrors the queue full source.
// - Status bit 1 reads 1 while the queue holds data and 0 when it is empty.
// - Bit 0 reads 1 once a queue overrun has happened.
// - Writing 1 to bit 0 clears the overrun flag and flushes the queue.
// - The routing register sits at index 0x0D and resets to all zeros.
// - A six-bit threshold, reset 001111, sets the queue level raising the threshold source.
// - Transmit complete rises only after the final bit has left the transmit shift register.
`timescale 1ns/1ps
`include "rirq_consts.vh"

module rirq_top (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_arst_n,
   // APB slave
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   // Radio core events, same clock
   input  wire        i_sync_event,
   input  wire        i_address_match_event,
   input  wire        i_payload_ready_event,
   input  wire        i_crc_pass_event,
   input  wire        i_queue_push,
   input  wire        i_queue_pop,
   input  wire        i_tx_frame_start,
   input  wire        i_tx_last_bit_out,
   // Asynchronous sources
   input  wire        i_recovered_bit_clock,
   input  wire        i_signal_strength_event,
   // Outputs to host and radio core
   output wire        o_irq_line0,
   output wire        o_irq_line1,
   output wire        o_irq,
   output wire        o_queue_flush
);

   // Word index match; a low address bit set makes the access unmapped
   // Shared by the read mux, the writes and the error answer
   function hit;
      input [7:0] addr;
      input [5:0] idx;
      begin
         hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
      end
   endfunction

   // Rising edge of a level against its value one clock earlier
   function went_high;
      input cur;
      input prev;
      begin
         went_high = cur & ~prev;
      end
   endfunction

   // Register map by word index
   //   0x0D route   [7:6] line 0 code, [5:4] line 1 code, [3] tx select
   //                [2] full, [1] holds data, [0] overrun, write 1 flushes
   //   0x10 mode    [1:0] data mode, [3:2] state, [4] address filter
   //   states       00 standby, 01 receive, 10 transmit, 11 sleep
   //   0x11 thresh  [5:0] level for the threshold source
   //   0x12 status  [0] line 0 rise, [1] line 1 rise, [2] overrun, [3] tx done
   //   0x13 mask    status layout, 1 lets the bit through
   //   0x14 count   [6:0] bytes held, read only
   //   other        error answer, reads zero

   // Register state
   // Routing full and holds-data bits are computed, not stored; overrun is held in ovr_q
   reg  [4:0]  cfg_q;
   reg  [4:0]  mode_q;
   reg  [5:0]  thresh_q;
   reg  [3:0]  istat_q;
   reg  [3:0]  imask_q;
   reg         ovr_q;
   reg  [6:0]  qcount_q;
   reg         tx_complete_event_q;
   reg         flush_q;
   // Bus answer state
   reg  [31:0] prdata_q;
   reg         pready_q;
   reg         pslverr_q;
   // Output flops
   reg         line0_q;
   reg         line1_q;
   reg         irq_q;
   // Edge history for status capture
   reg         line0_prev_q;
   reg         line1_prev_q;
   reg         tx_complete_event_prev_q;
   // Synchronisers
   reg  [1:0]  meta_q;
   reg  [1:0]  sync_q;

   // Bus decode; a write lands only at the access edge with pready
   wire        setup    = i_psel & ~i_penable;
   wire        wr_done  = i_psel & i_penable & pready_q & i_pwrite;
   wire        wr_cfg   = wr_done & hit(i_paddr, `RIRQ_IDX_CFG);

   // Queue status; threshold 0 holds its source high
   wire        q_full   = (qcount_q == `RIRQ_QDEPTH);
   wire        q_empty  = (qcount_q == 7'h00);
   wire        q_thresh = (qcount_q >= {1'b0, thresh_q});

   // Overrun set and clear
   wire        ovr_set  = i_queue_push & q_full;
   wire        ovr_clr  = wr_cfg & i_pwdata[`RIRQ_CFG_OVR];

   // Synchronised pins, second stage only
   wire        bitclk_s = sync_q[0];
   wire        sigstr_s = sync_q[1];

   // Internal nets
   wire        route0;
   wire        route1;
   wire [3:0]  ev;
   reg  [31:0] rd_d;
   reg         known_d;

   // Selection network; sources enter as levels
   // A core event must stay high until the clock edge sees it
   rirq_route u_route (
      .i_data_mode_sel         (mode_q[`RIRQ_MODE_DM_HI:`RIRQ_MODE_DM_LO]),
      .i_op_state              (mode_q[`RIRQ_MODE_ST_HI:`RIRQ_MODE_ST_LO]),
      .i_line0_rx_source_sel   (cfg_q[4:3]),
      .i_line1_rx_source_sel   (cfg_q[2:1]),
      .i_line1_tx_source_sel   (cfg_q[0]),
      .i_addr_filter_en        (mode_q[`RIRQ_MODE_AFILT]),
      .i_sync_event            (i_sync_event),
      .i_address_match_event   (i_address_match_event),
      .i_signal_strength_event (sigstr_s),
      .i_recovered_bit_clock   (bitclk_s),
      .i_byte_written_event    (i_queue_push),
      .i_payload_ready_event   (i_payload_ready_event),
      .i_crc_pass_event        (i_crc_pass_event),
      .i_tx_complete_event     (tx_complete_event_q),
      .i_queue_empty           (q_empty),
      .i_queue_full            (q_full),
      .i_queue_thresh          (q_thresh),
      .o_line0                 (route0),
      .o_line1                 (route1)
   );

   // Two-flop synchronisers; first stage feeds only the second
   // Two clocks of latency, three up to the line outputs
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= 2'h0;
         sync_q <= 2'h0;
      end else begin
         meta_q <= {i_signal_strength_event, i_recovered_bit_clock};
         sync_q <= meta_q;
      end
   end

   // Read mux; the routing register stores select bits high, status low
   // Status bits are live values, taken at the setup edge
   always @* begin
      rd_d    = 32'h0000_0000;
      known_d = 1'b1;
      if (hit(i_paddr, `RIRQ_IDX_CFG))
         rd_d[7:0] = {cfg_q, q_full, ~q_empty, ovr_q};
      else if (hit(i_paddr, `RIRQ_IDX_MODE))
         rd_d[4:0] = mode_q;
      else if (hit(i_paddr, `RIRQ_IDX_THRESH))
         rd_d[5:0] = thresh_q;
      else if (hit(i_paddr, `RIRQ_IDX_ISTAT))
         rd_d[3:0] = istat_q;
      else if (hit(i_paddr, `RIRQ_IDX_IMASK))
         rd_d[3:0] = imask_q;
      else if (hit(i_paddr, `RIRQ_IDX_QLEVEL))
         rd_d[6:0] = qcount_q;
      else
         known_d = 1'b0;
   end

   // APB answer: ready in the first access cycle, data latched at setup
   // No wait states, as the read mux settles within the setup cycle
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~known_d;
         if (setup && !i_pwrite)
            prdata_q <= rd_d;
         else if (!i_psel)
            prdata_q <= 32'h0000_0000;
      end
   end

   // Writable configuration; status bits of the routing word are not stored
   // Misaligned or unmapped writes miss every hit and change nothing
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg_q    <= `RIRQ_RST_CFG;
         mode_q   <= `RIRQ_RST_MODE;
         thresh_q <= `RIRQ_RST_THRESH;
         imask_q  <= `RIRQ_RST_IMASK;
      end else if (wr_done) begin
         if (hit(i_paddr, `RIRQ_IDX_CFG))
            cfg_q <= i_pwdata[`RIRQ_CFG_L0_HI:`RIRQ_CFG_TXSEL];
         if (hit(i_paddr, `RIRQ_IDX_MODE))
            mode_q <= i_pwdata[4:0];
         if (hit(i_paddr, `RIRQ_IDX_THRESH))
            thresh_q <= i_pwdata[5:0];
         if (hit(i_paddr, `RIRQ_IDX_IMASK))
            imask_q <= i_pwdata[3:0];
      end
   end

   // Overrun flag: a push into a full queue sets it, and set wins over clear
   // so an overrun landing on the clearing write is not lost
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         ovr_q <= 1'b0;
      else if (ovr_set)
         ovr_q <= 1'b1;
      else if (ovr_clr)
         ovr_q <= 1'b0;
   end

   // Flush pulse to the queue storage, one cycle after the clearing write
   // From a flop, so the core sees a clean single-clock pulse
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         flush_q <= 1'b0;
      else
         flush_q <= ovr_clr;
   end

   // Occupancy tracker; a full queue drops the incoming byte
   // Push with pop keeps the count, except at full or empty
   // The flushing write wins over both
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         qcount_q <= 7'h00;
      else if (ovr_clr)
         qcount_q <= 7'h00;
      else begin
         case ({i_queue_push & ~q_full, i_queue_pop & ~q_empty})
            2'b10:   qcount_q <= qcount_q + 7'h01;
            2'b01:   qcount_q <= qcount_q - 7'h01;
            default: qcount_q <= qcount_q;
         endcase
      end
   end

   // Transmit complete holds from the last shifted bit to the next frame
   // A last bit and a frame start together leave it set
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         tx_complete_event_q <= 1'b0;
      else if (i_tx_last_bit_out)
         tx_complete_event_q <= 1'b1;
      else if (i_tx_frame_start)
         tx_complete_event_q <= 1'b0;
   end

   // Line outputs registered, so a change shows within one clock
   // One clock of latency buys glitch-free lines
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         line0_q <= 1'b0;
         line1_q <= 1'b0;
      end else begin
         line0_q <= route0;
         line1_q <= route1;
      end
   end

   // Edge history so status bits catch rising edges only
   // Resets to the idle line level, so no false edge after reset
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         line0_prev_q  <= 1'b0;
         line1_prev_q  <= 1'b0;
         tx_complete_event_prev_q <= 1'b0;
      end else begin
         line0_prev_q  <= line0_q;
         line1_prev_q  <= line1_q;
         tx_complete_event_prev_q <= tx_complete_event_q;
      end
   end

   // Sticky events; the bit clock on line 1 would set bit 1 on every rising edge
   // Overrun records the setting event, not the held flag
   assign ev[`RIRQ_IS_LINE0]  = went_high(line0_q, line0_prev_q);
   assign ev[`RIRQ_IS_LINE1]  = went_high(line1_q, line1_prev_q);
   assign ev[`RIRQ_IS_OVR]    = ovr_set & ~ovr_q;
   assign ev[`RIRQ_IS_TX_COMPLETE_EVENT] = went_high(tx_complete_event_q, tx_complete_event_prev_q);

   // Write one to clear; a new event in the same cycle keeps the bit
   // The host clears after service, or the interrupt stays high
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         istat_q <= 4'h0;
      else if (wr_done && hit(i_paddr, `RIRQ_IDX_ISTAT))
         istat_q <= (istat_q & ~i_pwdata[3:0]) | ev;
      else
         istat_q <= istat_q | ev;
   end

   // Level interrupt from unmasked status
   // Masking drops the line next clock; the status bit stays
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         irq_q <= 1'b0;
      else
         irq_q <= |(istat_q & imask_q);
   end

   // Output drive, every one from a flop
   // Read data holds steady through the access cycle
   assign o_prdata      = prdata_q;
   assign o_pready      = pready_q;
   assign o_pslverr     = pslverr_q;
   assign o_irq_line0   = line0_q;
   assign o_irq_line1   = line1_q;
   assign o_irq         = irq_q;
   assign o_queue_flush = flush_q;

endmodule // rirq_top

// ---- rirq_monitor.sv ----
// Port checker for rirq_top: bus timing, flush pulse and line routing.
// Assumes the bind below on every rirq_top; one clock domain.
`timescale 1ns/1ps
module rirq_monitor (
   // Clock and reset
   input wire        i_clk,
   input wire        i_arst_n,
   // Bus
   input wire        i_psel,
   input wire        i_penable,
   input wire        i_pwrite,
   input wire [7:0]  i_paddr,
   input wire [31:0] i_pwdata,
   input wire [31:0] o_prdata,
   input wire        o_pready,
   input wire        o_pslverr,
   // Lines
   input wire        i_recovered_bit_clock,
   input wire        o_irq_line0,
   input wire        o_irq_line1,
   input wire        o_queue_flush
);
   reg  [3:0] mode_q;
   reg  [1:0] age_q;
   wire       wr_ok = i_psel & i_penable & o_pready & i_pwrite;
   // Shadow of mode register; age hides synchroniser history after reset
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_q <= 4'h0;
         age_q  <= 2'h0;
      end else begin
         if (wr_ok && i_paddr == 8'h40) mode_q <= i_pwdata[3:0];
         if (age_q != 2'h3) age_q <= age_q + 2'h1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   sequence s_setup; i_psel && !i_penable; endsequence
   sequence s_clear; wr_ok && i_paddr == 8'h34 && i_pwdata[0]; endsequence
   sequence s_flush; o_queue_flush ##1 !o_queue_flush; endsequence
   property p_ready_once; s_setup |=> o_pready ##1 !o_pready; endproperty
   property p_ready_cause; o_pready |-> $past(i_psel && !i_penable); endproperty
   property p_err_ready; o_pslverr |-> o_pready; endproperty
   property p_unmapped; s_setup and i_paddr[1:0] != 2'h0 |=> o_pslverr; endproperty
   property p_idle_data; !$past(i_psel) |-> o_prdata == 32'h0000_0000; endproperty
   property p_flush; s_clear |=> s_flush; endproperty
   property p_flush_cause; o_queue_flush |-> $past(wr_ok && i_paddr == 8'h34 && i_pwdata[0]); endproperty
   property p_sleep; mode_q[3:2] == 2'h3 && $past(mode_q[3:2]) == 2'h3 |-> !o_irq_line0 && !o_irq_line1; endproperty
   property p_bit_clock;
      age_q == 2'h3 && mode_q[1:0] == 2'h0 && mode_q[3:2] != 2'h3 && $past(mode_q) == mode_q
         && $past(mode_q, 2) == mode_q |-> o_irq_line1 == $past(i_recovered_bit_clock, 3);
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("pready not one cycle");
   a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
   a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
   a_unmapped: assert property (p_unmapped) else $error("misaligned address not refused");
   a_idle_data: assert property (p_idle_data) else $error("prdata not zero when idle");
   a_flush: assert property (p_flush) else $error("no flush pulse after clear");
   a_flush_cause: assert property (p_flush_cause) else $error("flush without clear");
   a_sleep: assert property (p_sleep) else $error("line active in sleep");
   a_bit_clock: assert property (p_bit_clock) else $error("line1 not bit clock");
endmodule // rirq_monitor

bind rirq_top rirq_monitor u_rirq_monitor (.i_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
   .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_recovered_bit_clock, .o_irq_line0, .o_irq_line1,
   .o_queue_flush);

// ---- rirq_host_model.sv ----
// Host side model: counts interrupt requests seen on the level output.
// Assumes the same clock as the block.
`timescale 1ns/1ps
module rirq_host_model (
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_arst_n,
   // Interrupt
   input  wire       i_irq,
   output reg  [7:0] o_irq_count
);
   reg irq_q;
   // Count rises only; a level held high is one request
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_q       <= 1'h0;
         o_irq_count <= 8'h00;
      end else begin
         irq_q <= i_irq;
         if (i_irq && !irq_q) o_irq_count <= o_irq_count + 8'h01;
      end
   end
endmodule // rirq_host_model

// ---- tb.sv ----
// Self-checking bench for rirq_top: registers, routing table, queue status.
// Assumes rirq_top, rirq_monitor and rirq_host_model are compiled first.
`timescale 1ns/1ps
module tb;
   logic        i_clk = 1'h0, i_arst_n = 1'h0;
   logic        i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
   logic [7:0]  i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic        i_sync_event = 1'h0, i_address_match_event = 1'h0, i_payload_ready_event = 1'h0;
   logic        i_crc_pass_event = 1'h0, i_queue_push = 1'h0, i_queue_pop = 1'h0;
   logic        i_tx_frame_start = 1'h0, i_tx_last_bit_out = 1'h0;
   logic        i_recovered_bit_clock = 1'h0, i_signal_strength_event = 1'h0;
   wire  [31:0] o_prdata;
   wire         o_pready, o_pslverr, o_irq_line0, o_irq_line1, o_irq, o_queue_flush;
   wire  [7:0]  irq_count;
   int          n_mismatch = 0, comparisons = 0;
   logic [33:0] exp_q[$], exp_r;
   logic [7:0]  rnd = 8'h21;
   logic [1:0]  dm, st, c0, c1, ex;
   logic        tx, td;

   rirq_top u_rirq_top (.i_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
      .o_pready, .o_pslverr, .i_sync_event, .i_address_match_event, .i_payload_ready_event, .i_crc_pass_event,
      .i_queue_push, .i_queue_pop, .i_tx_frame_start, .i_tx_last_bit_out, .i_recovered_bit_clock,
      .i_signal_strength_event, .o_irq_line0, .o_irq_line1, .o_irq, .o_queue_flush);
   rirq_host_model u_rirq_host_model (.i_clk, .i_arst_n, .i_irq(o_irq), .o_irq_count(irq_count));

   always #4 i_clk = ~i_clk;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Expected lines with empty queue, threshold 0; s: sync,match,payload,crc,bitclk,strength
   function automatic logic [1:0] route(input logic [5:0] s);
      logic l0, l1;
      if (dm == 2'h0) l0 = (c0 == 2'h1) ? s[5] : s[0];
      else if (c0 == 2'h3) l0 = (dm[1] && rnd[7]) ? s[1] : s[0];
      else l0 = (c0 == 2'h2) ? 1'h1 : (c0 == 2'h0 && dm[1]) ? s[2] : 1'h0;
      if (dm == 2'h0) l1 = s[4];
      else if (st == 2'h2) l1 = tx & td;
      else l1 = (c1 == 2'h3) ? 1'h1 : (c1 == 2'h2) ? s[5] : (c1 == 2'h0 && dm[1]) ? s[3] : 1'h0;
      return (st == 2'h3) ? 2'h0 : {l1, l0};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One bus transfer; read data and error code are noted for the watcher
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                      input logic er);
      int n;
      exp_q.push_back({~w, er, e});
      @(posedge i_clk);
      i_psel    <= 1'h1;
      i_penable <= 1'h0;
      i_pwrite  <= w;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_clk);
      i_penable <= 1'h1;
      for (n = 0; n < 16 && o_pready !== 1'h1; n++) @(posedge i_clk);
      if (n == 16) begin
         n_mismatch++;
         print_verdict();
      end
      i_psel    <= 1'h0;
      i_penable <= 1'h0;
   endtask

   // Watcher takes the oldest note at each completed transfer
   always @(posedge i_clk) begin
      if (i_psel && i_penable && o_pready === 1'h1) begin
         exp_r = exp_q.pop_front();
         check("pslverr", {31'h0, o_pslverr}, {31'h0, exp_r[32]});
         if (exp_r[33]) check("prdata", o_prdata, exp_r[31:0]);
      end
   end

   task automatic line_check(input string what, input logic seen, input logic exp);
      check(what, {31'h0, seen}, {31'h0, exp});
   endtask

   initial begin
      repeat (12) @(posedge i_clk);
      i_arst_n <= 1'h1;
      apb(1'h0, 8'h34, 32'h0, 32'h0000_0000, 1'h0);
      apb(1'h0, 8'h44, 32'h0, 32'h0000_000F, 1'h0);
      apb(1'h0, 8'hFC, 32'h0, 32'h0000_0000, 1'h1);
      apb(1'h1, 8'h35, 32'h0000_00FF, 32'h0, 1'h1);
      apb(1'h1, 8'h44, 32'h0000_0000, 32'h0, 1'h0);
      // Every data mode, state and select code, random source levels
      for (int i = 0; i < 256; i++) begin
         rnd = lfsr(rnd);
         {dm, st, c0, c1} = i[7:0];
         td = rnd[6];
         tx = rnd[3] ^ rnd[6];
         @(posedge i_clk);
         i_tx_last_bit_out <= td;
         i_tx_frame_start  <= ~td;
         {i_signal_strength_event, i_recovered_bit_clock, i_crc_pass_event, i_payload_ready_event,
          i_address_match_event, i_sync_event} <= rnd[5:0];
         @(posedge i_clk);
         i_tx_last_bit_out <= 1'h0;
         i_tx_frame_start  <= 1'h0;
         apb(1'h1, 8'h40, {27'h0, rnd[7], st, dm}, 32'h0, 1'h0);
         apb(1'h1, 8'h34, {24'h0, c0, c1, tx, 3'h0}, 32'h0, 1'h0);
         apb(1'h0, 8'h34, 32'h0, {24'h0, c0, c1, tx, 3'h0}, 1'h0);
         repeat (4) @(posedge i_clk);
         ex = route(rnd[5:0]);
         if (st != 2'h2) line_check("line0", o_irq_line0, ex[0]);
         line_check("line1", o_irq_line1, ex[1]);
      end
      // Buffer mode receive, line 1 on queue full, then fill past full
      @(posedge i_clk);
      {i_signal_strength_event, i_recovered_bit_clock, i_crc_pass_event, i_payload_ready_event,
       i_address_match_event, i_sync_event} <= 6'h00;
      apb(1'h1, 8'h40, 32'h0000_0005, 32'h0, 1'h0);
      apb(1'h1, 8'h34, 32'h0000_0010, 32'h0, 1'h0);
      repeat (4) @(posedge i_clk);
      apb(1'h1, 8'h48, 32'h0000_000F, 32'h0, 1'h0);
      for (int k = 0; k < 65; k++) begin
         @(posedge i_clk);
         i_queue_push <= 1'h1;
         @(posedge i_clk);
         i_queue_push <= 1'h0;
         if (k == 63) apb(1'h0, 8'h34, 32'h0, 32'h0000_0016, 1'h0);
         if (k == 63) line_check("line1 full", o_irq_line1, 1'h1);
      end
      repeat (3) @(posedge i_clk);
      apb(1'h0, 8'h34, 32'h0, 32'h0000_0017, 1'h0);
      apb(1'h0, 8'h50, 32'h0, 32'h0000_0040, 1'h0);
      line_check("irq masked", o_irq, 1'h0);
      apb(1'h1, 8'h4C, 32'h0000_0004, 32'h0, 1'h0);
      repeat (3) @(posedge i_clk);
      line_check("irq", o_irq, 1'h1);
      check("host irq count", {24'h0, irq_count}, 32'h0000_0001);
      apb(1'h1, 8'h34, 32'h0000_0011, 32'h0, 1'h0);
      apb(1'h0, 8'h34, 32'h0, 32'h0000_0010, 1'h0);
      apb(1'h0, 8'h50, 32'h0, 32'h0000_0000, 1'h0);
      line_check("irq sticky", o_irq, 1'h1);
      apb(1'h1, 8'h48, 32'h0000_0004, 32'h0, 1'h0);
      repeat (3) @(posedge i_clk);
      line_check("irq cleared", o_irq, 1'h0);
      print_verdict();
   end
endmodule // tb
